// *** common/mies_pkg.sv ***
// Package with constants and types for the instruction execution subset
// Overview of operation
// - Immediate minus accumulator minus borrow goes to accumulator, updates zero, digit-carry, carry.
// - Zero result sets zero flag; carry set when no borrow, cleared on borrow.
// - Halt entry clears watchdog counter and its prescaler to zero.
// - Halt entry sets timeout flag, clears power-down flag, then halts execution.
// - Special-page load copies accumulator to indexed register 0..15, flags unchanged.
// - Register minus accumulator on data register 0..63, updates zero, digit-carry, carry.
// - Register minus accumulator: destination bit zero to accumulator, one to register.
// - Nibble swap exchanges high and low nibbles of source, flags unchanged.
// - Nibble swap: destination bit zero to accumulator, one to source register.
package mies_pkg;
    localparam int          DATA_W       = 8;
    localparam int          REG_AW       = 6;
    localparam int          SFR_AW       = 4;
    localparam int          WDT_W        = 8;
    localparam int          PRESC_W      = 8;
    localparam logic [7:0]  RST_BYTE     = 8'h00;
    localparam logic        RST_TO_N     = 1'b1;
    localparam logic        RST_PD_N     = 1'b1;
    localparam logic        DEST_ACC     = 1'b0;
    localparam int          NIB_LO       = 0;
    localparam int          NIB_HI       = 4;

    typedef enum logic [2:0]
    {
        MIES_OP_NONE,
        MIES_OP_IMM_SUB_BORROW,
        MIES_OP_HALT,
        MIES_OP_SPECIAL_PAGE_LOAD,
        MIES_OP_REG_MINUS_ACC,
        MIES_OP_NIBBLE_SWAP
    } mies_op_e;
endpackage : mies_pkg

// *** common/mies_alu_if.sv ***
// Interface between the execution core and its arithmetic unit
`timescale 1ns/100ps
interface mies_alu_if;
    import mies_pkg::*;
    logic [DATA_W-1:0] a;
    logic [DATA_W-1:0] b;
    logic              cin;
    logic [DATA_W-1:0] sum;
    logic              z;
    logic              dc;
    logic              c;
    modport core (output a, output b, output cin, input sum, input z, input dc, input c);
    modport alu  (input a, input b, input cin, output sum, output z, output dc, output c);
endinterface : mies_alu_if

// *** hdl/mies_alu.sv ***
// Adder a + ~b + cin with zero, digit-carry and carry outputs
`timescale 1ns/100ps
module mies_alu
    import mies_pkg::*;
(
    mies_alu_if.alu alu
);
    logic [NIB_HI:0]   lo;
    logic [DATA_W:0]   full;

    // Subtraction as add of the complement: carry out high means no borrow
    always_comb
    begin
        lo   = {1'b0, alu.a[NIB_HI-1:0]} + {1'b0, ~alu.b[NIB_HI-1:0]} + {4'h0, alu.cin};
        full = {1'b0, alu.a} + {1'b0, ~alu.b} + {8'h00, alu.cin};
    end

    assign alu.sum = full[DATA_W-1:0];
    assign alu.z   = (full[DATA_W-1:0] == RST_BYTE);
    assign alu.dc  = lo[NIB_HI];
    assign alu.c   = full[DATA_W];
endmodule : mies_alu

// *** hdl/mies_core.sv ***
// Execution core for the halt, special-page, subtract and swap instructions
`timescale 1ns/100ps
module mies_core
    import mies_pkg::*;
(
    input  wire logic              i_clk_sys,
    input  wire logic              i_sys_rst,
    input  wire logic              i_valid,
    input  wire mies_op_e          i_op,
    input  wire logic [DATA_W-1:0] i_imm,
    input  wire logic [REG_AW-1:0] i_reg_idx,
    input  wire logic [SFR_AW-1:0] i_sfr_idx,
    input  wire logic              i_dest,
    input  wire logic              i_wake,
    input  wire logic [REG_AW-1:0] i_dbg_reg_idx,
    input  wire logic [SFR_AW-1:0] i_dbg_sfr_idx,
    output logic [DATA_W-1:0]      o_acc,
    output logic                   o_zero_flag,
    output logic                   o_digit_carry_flag,
    output logic                   o_carry_flag,
    output logic                   o_timeout_flag_n,
    output logic                   o_powerdown_flag_n,
    output logic [WDT_W-1:0]       o_watchdog_count,
    output logic [PRESC_W-1:0]     o_watchdog_prescaler,
    output logic                   o_halted,
    output logic [DATA_W-1:0]      o_dbg_reg,
    output logic [DATA_W-1:0]      o_dbg_sfr
);
    // ****************************************************************
    // Storage and arithmetic
    // ****************************************************************
    logic [DATA_W-1:0] regs [0:(1<<REG_AW)-1];
    logic [DATA_W-1:0] sfrs [0:(1<<SFR_AW)-1];
    logic [DATA_W-1:0] src;
    logic [DATA_W-1:0] swapped;
    logic              run;

    mies_alu_if alu_bus ();
    mies_alu u_alu (.alu(alu_bus.alu));

    assign src     = regs[i_reg_idx];
    assign swapped = {src[NIB_HI-1:NIB_LO], src[DATA_W-1:NIB_HI]};
    assign run     = i_valid && !o_halted;

    // Immediate form: i + ~ACC + C; register form: R + ~ACC + 1
    always_comb
    begin
        alu_bus.a   = (i_op == MIES_OP_IMM_SUB_BORROW) ? i_imm : src;
        alu_bus.b   = o_acc;
        alu_bus.cin = (i_op == MIES_OP_IMM_SUB_BORROW) ? o_carry_flag : 1'b1;
    end

    // ****************************************************************
    // Accumulator and flags
    // ****************************************************************
    always_ff @(posedge i_clk_sys)
    begin
        if (i_sys_rst)
        begin
            o_acc              <= RST_BYTE;
            o_zero_flag        <= 1'b0;
            o_digit_carry_flag <= 1'b0;
            o_carry_flag       <= 1'b0;
        end
        else if (run)
        begin
            case (i_op)
                MIES_OP_IMM_SUB_BORROW:
                begin
                    o_acc              <= alu_bus.sum;
                    o_zero_flag        <= alu_bus.z;
                    o_digit_carry_flag <= alu_bus.dc;
                    o_carry_flag       <= alu_bus.c;
                end
                MIES_OP_REG_MINUS_ACC:
                begin
                    if (i_dest == DEST_ACC)
                        o_acc <= alu_bus.sum;
                    o_zero_flag        <= alu_bus.z;
                    o_digit_carry_flag <= alu_bus.dc;
                    o_carry_flag       <= alu_bus.c;
                end
                MIES_OP_NIBBLE_SWAP:
                begin
                    if (i_dest == DEST_ACC)
                        o_acc <= swapped;
                end
                default:
                begin
                end
            endcase
        end
    end

    // ****************************************************************
    // Data registers and special page
    // ****************************************************************
    // Cleared on reset so that a register source is never unknown
    for (genvar g = 0; g < (1 << REG_AW); g++)
    begin : g_data_reg
        always_ff @(posedge i_clk_sys)
        begin
            if (i_sys_rst)
                regs[g] <= RST_BYTE;
            else if (run && i_dest != DEST_ACC && i_reg_idx == REG_AW'(g))
            begin
                if (i_op == MIES_OP_REG_MINUS_ACC)
                    regs[g] <= alu_bus.sum;
                else if (i_op == MIES_OP_NIBBLE_SWAP)
                    regs[g] <= swapped;
            end
        end
    end

    always_ff @(posedge i_clk_sys)
    begin
        if (run && i_op == MIES_OP_SPECIAL_PAGE_LOAD)
            sfrs[i_sfr_idx] <= o_acc;
    end

    always_ff @(posedge i_clk_sys)
    begin
        o_dbg_reg <= regs[i_dbg_reg_idx];
        o_dbg_sfr <= sfrs[i_dbg_sfr_idx];
    end

    // ****************************************************************
    // Halt, watchdog and power flags
    // ****************************************************************
    logic halt_now;
    assign halt_now = run && i_op == MIES_OP_HALT;

    always_ff @(posedge i_clk_sys)
    begin
        if (i_sys_rst)
        begin
            o_timeout_flag_n   <= RST_TO_N;
            o_powerdown_flag_n <= RST_PD_N;
            o_halted           <= 1'b0;
        end
        else if (halt_now)
        begin
            o_timeout_flag_n   <= 1'b1;
            o_powerdown_flag_n <= 1'b0;
            o_halted           <= 1'b1;
        end
        else if (i_wake)
            o_halted <= 1'b0;
    end

    // Watchdog stops while halted; wake-up and timeout handling lies elsewhere
    always_ff @(posedge i_clk_sys)
    begin
        if (i_sys_rst || halt_now)
        begin
            o_watchdog_count     <= RST_BYTE;
            o_watchdog_prescaler <= RST_BYTE;
        end
        else if (!o_halted)
        begin
            o_watchdog_prescaler <= o_watchdog_prescaler + 8'h01;
            if (o_watchdog_prescaler == 8'hFF)
                o_watchdog_count <= o_watchdog_count + 8'h01;
        end
    end

    // ****************************************************************
    // Checks
    // ****************************************************************
    sequence s_halt_issued;
        i_valid && !o_halted && i_op == MIES_OP_HALT;
    endsequence

    property p_halt_flags;
        @(posedge i_clk_sys) disable iff (i_sys_rst)
        s_halt_issued |=> o_timeout_flag_n && !o_powerdown_flag_n && o_halted;
    endproperty
    a_halt_flags: assert property (p_halt_flags) else $error("halt flags wrong");

    property p_halt_wdt;
        @(posedge i_clk_sys) disable iff (i_sys_rst)
        s_halt_issued |=> o_watchdog_count == 8'h00 && o_watchdog_prescaler == 8'h00;
    endproperty
    a_halt_wdt: assert property (p_halt_wdt) else $error("watchdog not cleared");

    property p_imm_sub;
        @(posedge i_clk_sys) disable iff (i_sys_rst)
        (run && i_op == MIES_OP_IMM_SUB_BORROW) |=>
            {o_carry_flag, o_acc} == ({1'b0, $past(i_imm)} + {1'b0, ~$past(o_acc)} + 9'($past(o_carry_flag)));
    endproperty
    a_imm_sub: assert property (p_imm_sub) else $error("immediate subtract wrong");

    property p_imm_zero;
        @(posedge i_clk_sys) disable iff (i_sys_rst)
        (run && i_op == MIES_OP_IMM_SUB_BORROW) |=> o_zero_flag == (o_acc == 8'h00);
    endproperty
    a_imm_zero: assert property (p_imm_zero) else $error("zero flag wrong");

    property p_rma_acc;
        @(posedge i_clk_sys) disable iff (i_sys_rst)
        (run && i_op == MIES_OP_REG_MINUS_ACC && i_dest == 1'b0) |=>
            o_acc == 8'($past(src) - $past(o_acc)) && o_carry_flag == ($past(src) >= $past(o_acc));
    endproperty
    a_rma_acc: assert property (p_rma_acc) else $error("register subtract wrong");

    property p_rma_reg;
        @(posedge i_clk_sys) disable iff (i_sys_rst)
        (run && i_op == MIES_OP_REG_MINUS_ACC && i_dest == 1'b1) |=> $stable(o_acc);
    endproperty
    a_rma_reg: assert property (p_rma_reg) else $error("accumulator written");

    property p_swap;
        @(posedge i_clk_sys) disable iff (i_sys_rst)
        (run && i_op == MIES_OP_NIBBLE_SWAP && i_dest == 1'b0) |=>
            o_acc == {$past(src[3:0]), $past(src[7:4])} && $stable(o_carry_flag) && $stable(o_zero_flag);
    endproperty
    a_swap: assert property (p_swap) else $error("swap wrong");

    property p_swap_reg;
        @(posedge i_clk_sys) disable iff (i_sys_rst)
        (run && i_op == MIES_OP_NIBBLE_SWAP && i_dest == 1'b1) |=> $stable(o_acc);
    endproperty
    a_swap_reg: assert property (p_swap_reg) else $error("swap hit accumulator");

    property p_sfr_flags;
        @(posedge i_clk_sys) disable iff (i_sys_rst)
        (run && i_op == MIES_OP_SPECIAL_PAGE_LOAD) |=>
            $stable(o_acc) && $stable(o_carry_flag) && $stable(o_zero_flag) && $stable(o_digit_carry_flag);
    endproperty
    a_sfr_flags: assert property (p_sfr_flags) else $error("special load touched flags");

    property p_halted_idle;
        @(posedge i_clk_sys) disable iff (i_sys_rst)
        (o_halted && !i_wake) |=> $stable(o_acc) && o_halted;
    endproperty
    a_halted_idle: assert property (p_halted_idle) else $error("executed while halted");
endmodule : mies_core

// *** testbench/tb_mies_core.sv ***
// Self-checking testbench for the instruction execution core
`timescale 1ns/100ps
module tb_mies_core
    import mies_pkg::*;
;
    logic              i_clk_sys;
    logic              i_sys_rst;
    logic              i_valid;
    mies_op_e          i_op;
    logic [DATA_W-1:0] i_imm;
    logic [REG_AW-1:0] i_reg_idx;
    logic [SFR_AW-1:0] i_sfr_idx;
    logic              i_dest;
    logic              i_wake;
    logic [REG_AW-1:0] i_dbg_reg_idx;
    logic [SFR_AW-1:0] i_dbg_sfr_idx;
    logic [DATA_W-1:0] o_acc;
    logic              o_zero_flag;
    logic              o_digit_carry_flag;
    logic              o_carry_flag;
    logic              o_timeout_flag_n;
    logic              o_powerdown_flag_n;
    logic [WDT_W-1:0]  o_watchdog_count;
    logic [PRESC_W-1:0] o_watchdog_prescaler;
    logic              o_halted;
    logic [DATA_W-1:0] o_dbg_reg;
    logic [DATA_W-1:0] o_dbg_sfr;
    int                miscompares;
    int                checks_done;
    logic [7:0]        acc_m;
    logic              c_m;
    logic              z_m;
    logic              dc_m;
    logic [7:0]        r_m;
    logic [7:0]        sfr_top;
    logic [7:0]        imms [8] = '{8'h07, 8'h05, 8'h06, 8'h05, 8'h00, 8'hFF, 8'h10, 8'h3C};

    mies_core u_dut
    (
        .i_clk_sys            (i_clk_sys),
        .i_sys_rst            (i_sys_rst),
        .i_valid              (i_valid),
        .i_op                 (i_op),
        .i_imm                (i_imm),
        .i_reg_idx            (i_reg_idx),
        .i_sfr_idx            (i_sfr_idx),
        .i_dest               (i_dest),
        .i_wake               (i_wake),
        .i_dbg_reg_idx        (i_dbg_reg_idx),
        .i_dbg_sfr_idx        (i_dbg_sfr_idx),
        .o_acc                (o_acc),
        .o_zero_flag          (o_zero_flag),
        .o_digit_carry_flag   (o_digit_carry_flag),
        .o_carry_flag         (o_carry_flag),
        .o_timeout_flag_n     (o_timeout_flag_n),
        .o_powerdown_flag_n   (o_powerdown_flag_n),
        .o_watchdog_count     (o_watchdog_count),
        .o_watchdog_prescaler (o_watchdog_prescaler),
        .o_halted             (o_halted),
        .o_dbg_reg            (o_dbg_reg),
        .o_dbg_sfr            (o_dbg_sfr)
    );

    always #5 i_clk_sys = ~i_clk_sys;

    task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
        checks_done++;
        if (seen !== exp)
        begin
            miscompares++;
            $display("ERROR at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask : chk

    // Drives one instruction at the falling edge, returns at the next falling edge
    task automatic issue(input mies_op_e op, input logic [7:0] imm, input logic [5:0] ri,
                         input logic [3:0] si, input logic d);
        i_valid   = 1'b1;
        i_op      = op;
        i_imm     = imm;
        i_reg_idx = ri;
        i_sfr_idx = si;
        i_dest    = d;
        @(negedge i_clk_sys);
    endtask : issue

    task automatic sbc(input logic [7:0] imm);
        logic [8:0] s;
        logic [4:0] lo;
        s  = {1'b0, imm} + {1'b0, ~acc_m} + {8'h00, c_m};
        lo = {1'b0, imm[3:0]} + {1'b0, ~acc_m[3:0]} + {4'h0, c_m};
        issue(MIES_OP_IMM_SUB_BORROW, imm, 6'h00, 4'h0, 1'b0);
        acc_m = s[7:0];
        c_m   = s[8];
        z_m   = (s[7:0] == 8'h00);
        dc_m  = lo[4];
        chk(o_acc, acc_m);
        chk({7'h00, o_carry_flag}, {7'h00, c_m});
        chk({7'h00, o_zero_flag}, {7'h00, acc_m == 8'h00});
        chk({7'h00, o_digit_carry_flag}, {7'h00, lo[4]});
    endtask : sbc

    // Register minus accumulator: two's complement, carry means no borrow
    task automatic rma(input logic [5:0] ri, input logic [7:0] r, input logic d);
        logic [8:0] s;
        logic [4:0] lo;
        s  = {1'b0, r} + {1'b0, ~acc_m} + 9'h001;
        lo = {1'b0, r[3:0]} + {1'b0, ~acc_m[3:0]} + 5'h01;
        issue(MIES_OP_REG_MINUS_ACC, 8'h00, ri, 4'h0, d);
        c_m  = s[8];
        z_m  = (s[7:0] == 8'h00);
        dc_m = lo[4];
        if (d)
            r_m = s[7:0];
        else
            acc_m = s[7:0];
        chk(o_acc, acc_m);
        chk({5'h00, o_zero_flag, o_digit_carry_flag, o_carry_flag}, {5'h00, z_m, dc_m, c_m});
    endtask : rma

    // Debug read port answers one cycle after the index is set
    task automatic peek(input logic [5:0] ri, input logic [7:0] exp);
        i_valid       = 1'b0;
        i_dbg_reg_idx = ri;
        @(negedge i_clk_sys);
        chk(o_dbg_reg, exp);
    endtask : peek

    task automatic summarize();
        $display("Checks done %0d, miscompares %0d", checks_done, miscompares);
        if (miscompares == 0 && checks_done > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask : summarize

    initial
    begin
        #(2000 * 10);
        miscompares++;
        summarize();
    end

    initial
    begin
        {i_clk_sys, i_valid, i_imm, i_reg_idx, i_sfr_idx, i_dest, i_wake} = '0;
        {i_dbg_reg_idx, i_dbg_sfr_idx} = '0;
        i_op          = MIES_OP_NONE;
        i_sys_rst     = 1'b1;
        miscompares   = 0;
        checks_done   = 0;
        acc_m         = 8'h00;
        c_m           = 1'b0;
        z_m           = 1'b0;
        dc_m          = 1'b0;
        r_m           = 8'h00;
        sfr_top       = 8'h00;
        repeat (20) @(posedge i_clk_sys);
        @(negedge i_clk_sys);
        i_sys_rst = 1'b0;
        chk(o_acc, 8'h00);
        chk({6'h00, o_timeout_flag_n, o_powerdown_flag_n}, 8'h03);
        // ***************************************************************
        // Subtract with borrow, back to back every cycle
        // ***************************************************************
        foreach (imms[i])
            sbc(imms[i]);
        // ***************************************************************
        // Special page loads at both ends of the index range
        // ***************************************************************
        sbc(8'hA5);
        sfr_top = acc_m;
        issue(MIES_OP_SPECIAL_PAGE_LOAD, 8'h00, 6'h00, 4'hF, 1'b0);
        sbc(8'h3C);
        issue(MIES_OP_SPECIAL_PAGE_LOAD, 8'h00, 6'h00, 4'h0, 1'b0);
        chk({5'h00, o_zero_flag, o_digit_carry_flag, o_carry_flag},
            {5'h00, z_m, dc_m, c_m});
        i_valid       = 1'b0;
        i_dbg_sfr_idx = 4'hF;
        @(negedge i_clk_sys);
        chk(o_dbg_sfr, sfr_top);
        i_dbg_sfr_idx = 4'h0;
        @(negedge i_clk_sys);
        chk(o_dbg_sfr, acc_m);
        // ***************************************************************
        // Register and accumulator destinations of subtract and swap
        // Data registers clear on reset, so zero minus the accumulator seeds one
        // ***************************************************************
        rma(6'h3F, 8'h00, 1'b1);
        peek(6'h3F, r_m);
        issue(MIES_OP_NIBBLE_SWAP, 8'h00, 6'h3F, 4'h0, 1'b1);
        chk(o_acc, acc_m);
        chk({7'h00, o_carry_flag}, {7'h00, c_m});
        r_m = {r_m[3:0], r_m[7:4]};
        peek(6'h3F, r_m);
        issue(MIES_OP_NIBBLE_SWAP, 8'h00, 6'h3F, 4'h0, 1'b0);
        acc_m = {r_m[3:0], r_m[7:4]};
        chk(o_acc, acc_m);
        chk({5'h00, o_zero_flag, o_digit_carry_flag, o_carry_flag}, {5'h00, z_m, dc_m, c_m});
        rma(6'h3F, r_m, 1'b0);
        rma(6'h00, 8'h00, 1'b1);
        peek(6'h00, r_m);
        // ***************************************************************
        // Halt entry, refusal while halted, wake
        // ***************************************************************
        chk({7'h00, o_watchdog_prescaler != 8'h00}, 8'h01);
        issue(MIES_OP_HALT, 8'h00, 6'h00, 4'h0, 1'b0);
        chk(o_watchdog_count, 8'h00);
        chk(o_watchdog_prescaler, 8'h00);
        chk({6'h00, o_timeout_flag_n, o_powerdown_flag_n}, 8'h02);
        chk({7'h00, o_halted}, 8'h01);
        issue(MIES_OP_IMM_SUB_BORROW, 8'h77, 6'h00, 4'h0, 1'b0);
        chk(o_acc, acc_m);
        chk(o_watchdog_prescaler, 8'h00);
        i_valid = 1'b0;
        i_wake  = 1'b1;
        @(negedge i_clk_sys);
        i_wake = 1'b0;
        chk({7'h00, o_halted}, 8'h00);
        sbc(8'h42);
        summarize();
    end
endmodule : tb_mies_core
